/* core/tarm_pkg.sv */
`default_nettype none

package tarm_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_PS  = 4000;  // Period of ref_clk in ps
  localparam int US_NS          = 1000;  // One microsecond in ns
  localparam int US_CYCLES      = (US_NS * 1000) / CLK_PERIOD_PS;
  localparam int US_CNT_W       = 8;     // Width of the microsecond counter

  // Trigger bus pulse width
  localparam int PULSE_WIDTH_NS = 1000;  // Pulse width in ns
  localparam int PULSE_CYCLES   = (PULSE_WIDTH_NS * 1000) / CLK_PERIOD_PS;
  localparam int PULSE_CNT_W    = 8;     // Width of the pulse counter

  // Bus and setting widths
  localparam int BUS_LINES      = 8;     // Trigger bus lines
  localparam int SEL_W          = 5;     // Arm origin code width
  localparam int REPEAT_W       = 31;    // Arm repeat total width
  localparam int DELAY_W        = 32;    // Arm delay width in microseconds

  // Arm origin codes
  localparam logic [SEL_W-1:0] SEL_IMMEDIATE = 5'h00;
  localparam logic [SEL_W-1:0] SEL_PATTERN   = 5'h01;
  localparam logic [SEL_W-1:0] SEL_RISE_BASE = 5'h02;
  localparam logic [SEL_W-1:0] SEL_FALL_BASE = 5'h0A;
  localparam logic [SEL_W-1:0] SEL_LAST      = 5'h11;

  // Values after reset
  localparam logic [SEL_W-1:0]    ARM_SEL_RST    = SEL_IMMEDIATE;
  localparam logic [REPEAT_W-1:0] ARM_REPEAT_RST = 31'h00000001;
  localparam logic [DELAY_W-1:0]  ARM_DELAY_RST  = 32'h00000000;

  // Layers of the trigger state machine
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_DELAY,
    ST_TRIGGER_LAYER
  } tarm_state_t;

endpackage : tarm_pkg

`default_nettype wire

/* core/tarm_pulse_gen.sv */
`default_nettype none

module tarm_pulse_gen
  import tarm_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Request
  input  wire logic pulseStart,
  // Pin drive
  output var  logic pinOut,
  output var  logic pinOe_n
);

  localparam logic [PULSE_CNT_W-1:0] CntLast =
    PULSE_CNT_W'(PULSE_CYCLES - 1);

  logic                   active_ff;   // Pulse in progress
  logic                   nxt_active;
  logic [PULSE_CNT_W-1:0] cnt_ff;      // Cycles of the pulse so far
  logic [PULSE_CNT_W-1:0] nxt_cnt;

  // Next pulse state
  always_comb begin
    nxt_active = active_ff;
    nxt_cnt    = cnt_ff;
    if (active_ff) begin
      // A new request is ignored while the pulse runs
      if (cnt_ff == CntLast) begin
        nxt_active = 1'b0;
        nxt_cnt    = '0;
      end else begin
        nxt_cnt = cnt_ff + PULSE_CNT_W'(1);
      end
    end else if (pulseStart) begin
      nxt_active = 1'b1;
      nxt_cnt    = '0;
    end
  end

  // Pulse registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_ff <= 1'b0;
      cnt_ff    <= '0;
      pinOut    <= 1'b0;
      pinOe_n   <= 1'b1;
    end else begin
      active_ff <= nxt_active;
      cnt_ff    <= nxt_cnt;
      pinOut    <= nxt_active;
      pinOe_n   <= ~nxt_active;
    end
  end

  localparam int PulseHold = PULSE_CYCLES - 1;

  property p_pulse_width;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(pinOut) |-> ##PulseHold pinOut ##1 !pinOut;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("Trigger bus pulse width wrong");

  property p_no_retrigger;
    @(posedge ref_clk) disable iff (!arst_n)
      pinOut && pulseStart && cnt_ff != CntLast |=> pinOut && !$rose(pinOut)
        && cnt_ff == $past(cnt_ff) + PULSE_CNT_W'(1);
  endproperty
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("Pulse restarted while active");

  property p_drive_enable;
    @(posedge ref_clk) disable iff (!arst_n)
      pinOe_n == !pinOut;
  endproperty
  a_drive_enable: assert property (p_drive_enable)
    else $error("Output enable disagrees with pulse");

endmodule : tarm_pulse_gen

`default_nettype wire

/* core/tarm_arm_layer_ctrl.sv */
`default_nettype none

// Functional notes
// - Eight-bit mask pulses each selected bus line
// - Each emitted bus pulse lasts one microsecond
// - Repeat total zero means re-arm forever
// - Wait for arm events repeat-total times
// - Full trigger layer runs after each arm
// - Arm delay microseconds, resets to zero
// - Arm delay elapses before entering trigger layer; immediate origin skips it
// - Delay rounds to nearest whole sample period
// - Origin codes 0..17, immediate after reset
// - Immediate origin bypasses the arm layer
// - Pattern origin accepts combined arm events
// - Rising edge origin arms on low-to-high
// - Falling edge origin arms on high-to-low
// - Repeat total resets to one
module tarm_arm_layer_ctrl
  import tarm_pkg::*;
#(
  parameter int LINES = BUS_LINES
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // Settings from software
  input  wire logic                cfgLoad,
  input  wire logic [REPEAT_W-1:0] arm_repeat_total,
  input  wire logic [SEL_W-1:0]    arm_origin_select,
  input  wire logic [DELAY_W-1:0]  armDelayUs,
  input  wire logic [DELAY_W-1:0]  samplePeriodUs,
  // Bus pulse request
  input  wire logic                pulseReq,
  input  wire logic [LINES-1:0]    bus_line_pulse_mask,
  // Sequence control
  input  wire logic                initiate,
  input  wire logic                patternArmEvent,
  input  wire logic                trigLayerDone,
  // Trigger bus pins
  input  wire logic [LINES-1:0]    trigBusIn,
  output var  logic [LINES-1:0]    trigBusOut,
  output var  logic [LINES-1:0]    trigBusOe_n,
  // Status
  output var  logic                armLayerActive,
  output var  logic                armDelayActive,
  output var  logic                trigger_layer,
  output var  logic                sequenceDone,
  output var  logic [REPEAT_W-1:0] armsCompleted
);

  // Settings held by the block
  logic [REPEAT_W-1:0] armRepeat_ff;   // Arm repeat total
  logic [REPEAT_W-1:0] nxt_armRepeat;
  logic [SEL_W-1:0]    armSel_ff;      // Arm origin code
  logic [SEL_W-1:0]    nxt_armSel;
  logic [DELAY_W-1:0]  armDelay_ff;    // Arm delay in microseconds
  logic [DELAY_W-1:0]  nxt_armDelay;

  // Trigger bus input synchroniser stages
  logic [LINES-1:0]    syncA_ff;       // First stage
  logic [LINES-1:0]    syncB_ff;       // Second stage
  logic [LINES-1:0]    syncC_ff;       // Previous value for edges
  logic [LINES-1:0]    lineRise;       // Low-to-high seen per line
  logic [LINES-1:0]    lineFall;       // High-to-low seen per line
  logic                armEvent;       // Arm event from chosen origin

  // Sequencer state
  tarm_state_t         state_ff;
  tarm_state_t         nxt_state;
  logic [REPEAT_W-1:0] armsDone_ff;    // Arm events taken this sequence
  logic [REPEAT_W-1:0] nxt_armsDone;
  logic                seqDone_ff;     // One-cycle end of sequence
  logic                nxt_seqDone;
  logic                moreArms;       // Another arm pass is due

  // Delay timing
  logic [DELAY_W:0]    rem_ff;         // Rounded delay still to run
  logic [DELAY_W:0]    nxt_rem;
  logic [DELAY_W-1:0]  perCnt_ff;      // Microseconds into this period
  logic [DELAY_W-1:0]  nxt_perCnt;
  logic [US_CNT_W-1:0] usCnt_ff;       // Cycles into this microsecond
  logic [US_CNT_W-1:0] nxt_usCnt;
  logic                usTick;         // Last cycle of a microsecond
  logic                delayOver;      // Less than one period left

  localparam logic [US_CNT_W-1:0] UsLast = US_CNT_W'(US_CYCLES - 1);

  // Next settings on a load strobe
  always_comb begin
    nxt_armRepeat = armRepeat_ff;
    nxt_armSel    = armSel_ff;
    nxt_armDelay  = armDelay_ff;
    if (cfgLoad) begin
      nxt_armRepeat = arm_repeat_total;
      nxt_armSel    = arm_origin_select;
      nxt_armDelay  = armDelayUs;
    end
  end

  // Setting registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      armRepeat_ff <= ARM_REPEAT_RST;
      armSel_ff    <= ARM_SEL_RST;
      armDelay_ff  <= ARM_DELAY_RST;
    end else begin
      armRepeat_ff <= nxt_armRepeat;
      armSel_ff    <= nxt_armSel;
      armDelay_ff  <= nxt_armDelay;
    end
  end

  // Three stages per line; the second and third stages feed edge logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      syncC_ff <= '0;
    end else begin
      syncA_ff <= trigBusIn;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end

  // Per-line edge detectors and pulse generators
  for (genvar k = 0; k < LINES; k++) begin : g_line
    assign lineRise[k] = syncB_ff[k] & ~syncC_ff[k];
    assign lineFall[k] = ~syncB_ff[k] & syncC_ff[k];

    tarm_pulse_gen u_pulse (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .pulseStart (pulseReq & bus_line_pulse_mask[k]),
      .pinOut     (trigBusOut[k]),
      .pinOe_n    (trigBusOe_n[k])
    );
  end

  // Arm event from the chosen origin; codes above the last never arm
  always_comb begin
    armEvent = 1'b0;
    if (armSel_ff == SEL_PATTERN) begin
      armEvent = patternArmEvent;
    end else if (armSel_ff >= SEL_RISE_BASE && armSel_ff < SEL_FALL_BASE) begin
      armEvent = lineRise[3'(armSel_ff - SEL_RISE_BASE)];
    end else if (armSel_ff >= SEL_FALL_BASE && armSel_ff <= SEL_LAST) begin
      armEvent = lineFall[3'(armSel_ff - SEL_FALL_BASE)];
    end
  end

  // Time base and rounded-period comparison
  assign usTick    = (usCnt_ff == UsLast);
  assign delayOver = (samplePeriodUs == '0) ||
                     (rem_ff < {1'b0, samplePeriodUs});
  assign moreArms  = (armRepeat_ff == '0) ||
                     (armsDone_ff < armRepeat_ff);

  // Next sequencer and delay state
  always_comb begin
    nxt_state    = state_ff;
    nxt_armsDone = armsDone_ff;
    nxt_seqDone  = 1'b0;
    nxt_rem      = rem_ff;
    nxt_perCnt   = perCnt_ff;
    nxt_usCnt    = usCnt_ff;
    unique case (state_ff)
      // Initial layer: wait for the sequence to be started
      ST_IDLE: begin
        if (initiate) begin
          if (armSel_ff == SEL_IMMEDIATE) begin
            nxt_state    = ST_TRIGGER_LAYER;
            nxt_armsDone = REPEAT_W'(1);
          end else begin
            nxt_state    = ST_ARM;
            nxt_armsDone = '0;
          end
        end
      end
      // Arm layer: wait for one arm event
      ST_ARM: begin
        if (armEvent) begin
          nxt_state    = ST_DELAY;
          nxt_armsDone = armsDone_ff + REPEAT_W'(1);
          // Adding half a period rounds to the nearest period
          nxt_rem      = {1'b0, armDelay_ff} +
                         {2'b00, samplePeriodUs[DELAY_W-1:1]};
          nxt_perCnt   = '0;
          nxt_usCnt    = '0;
        end
      end
      // Arm delay: run whole sample periods
      ST_DELAY: begin
        if (delayOver) begin
          nxt_state = ST_TRIGGER_LAYER;
        end else begin
          nxt_usCnt = usTick ? '0 : usCnt_ff + US_CNT_W'(1);
          if (usTick) begin
            if (perCnt_ff == samplePeriodUs - DELAY_W'(1)) begin
              nxt_perCnt = '0;
              nxt_rem    = rem_ff - {1'b0, samplePeriodUs};
            end else begin
              nxt_perCnt = perCnt_ff + DELAY_W'(1);
            end
          end
        end
      end
      // Trigger layer: wait until all trigger counts are done
      ST_TRIGGER_LAYER: begin
        if (trigLayerDone) begin
          if (!moreArms) begin
            nxt_state   = ST_IDLE;
            nxt_seqDone = 1'b1;
          end else if (armSel_ff == SEL_IMMEDIATE) begin
            nxt_state    = ST_TRIGGER_LAYER;
            nxt_armsDone = armsDone_ff + REPEAT_W'(1);
          end else begin
            nxt_state = ST_ARM;
          end
        end
      end
    endcase
  end

  // Sequencer registers and status outputs
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff       <= ST_IDLE;
      armsDone_ff    <= '0;
      seqDone_ff     <= 1'b0;
      rem_ff         <= '0;
      perCnt_ff      <= '0;
      usCnt_ff       <= '0;
      armLayerActive <= 1'b0;
      armDelayActive <= 1'b0;
      trigger_layer  <= 1'b0;
      sequenceDone   <= 1'b0;
      armsCompleted  <= '0;
    end else begin
      state_ff       <= nxt_state;
      armsDone_ff    <= nxt_armsDone;
      seqDone_ff     <= nxt_seqDone;
      rem_ff         <= nxt_rem;
      perCnt_ff      <= nxt_perCnt;
      usCnt_ff       <= nxt_usCnt;
      armLayerActive <= (nxt_state == ST_ARM);
      armDelayActive <= (nxt_state == ST_DELAY);
      trigger_layer  <= (nxt_state == ST_TRIGGER_LAYER);
      sequenceDone   <= nxt_seqDone;
      armsCompleted  <= nxt_armsDone;
    end
  end

  property p_mask_pulses;
    @(posedge ref_clk) disable iff (!arst_n)
      pulseReq && (trigBusOut & bus_line_pulse_mask) == '0 |=>
        (trigBusOut & $past(bus_line_pulse_mask)) ==
        $past(bus_line_pulse_mask);
  endproperty
  a_mask_pulses: assert property (p_mask_pulses)
    else $error("Masked bus line did not pulse");

  property p_immediate_skip;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_IDLE && initiate && armSel_ff == SEL_IMMEDIATE |=>
        state_ff == ST_TRIGGER_LAYER && trigger_layer && !armLayerActive;
  endproperty
  a_immediate_skip: assert property (p_immediate_skip)
    else $error("Immediate origin did not skip arm layer");

  property p_rise_arm;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_ARM && armSel_ff == SEL_RISE_BASE &&
        syncB_ff[0] && !syncC_ff[0] |=> state_ff == ST_DELAY;
  endproperty
  a_rise_arm: assert property (p_rise_arm)
    else $error("Rising edge on line 0 did not arm");

  property p_fall_arm;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_ARM && armSel_ff == SEL_LAST &&
        !syncB_ff[7] && syncC_ff[7] |=> state_ff == ST_DELAY;
  endproperty
  a_fall_arm: assert property (p_fall_arm)
    else $error("Falling edge on line 7 did not arm");

  property p_single_event;
    @(posedge ref_clk) disable iff (!arst_n)
      armEvent && armSel_ff >= SEL_RISE_BASE && $stable(armSel_ff) |=>
        !armEvent;
  endproperty
  a_single_event: assert property (p_single_event)
    else $error("Edge produced a multi-cycle arm event");

  property p_zero_delay;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_ARM && armEvent && armDelay_ff == '0 &&
        samplePeriodUs != '0 |=> state_ff == ST_DELAY ##1 trigger_layer;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("Delay under half a period was applied");

  property p_delay_holds;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_DELAY && !delayOver |=> !trigger_layer;
  endproperty
  a_delay_holds: assert property (p_delay_holds)
    else $error("Trigger layer entered before arm delay");

  property p_finish;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_TRIGGER_LAYER && trigLayerDone && armRepeat_ff != '0 &&
        armsDone_ff >= armRepeat_ff |=> state_ff == ST_IDLE && sequenceDone;
  endproperty
  a_finish: assert property (p_finish)
    else $error("Sequence did not end after last arm");

  property p_rearm;
    @(posedge ref_clk) disable iff (!arst_n)
      state_ff == ST_TRIGGER_LAYER && trigLayerDone && armSel_ff != SEL_IMMEDIATE &&
        (armRepeat_ff == '0 || armsDone_ff < armRepeat_ff) |=>
        armLayerActive && !sequenceDone;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("Machine did not return to arm layer");

  property p_reset_settings;
    @(posedge ref_clk)
      $rose(arst_n) |-> armRepeat_ff == ARM_REPEAT_RST &&
        armDelay_ff == ARM_DELAY_RST && armSel_ff == ARM_SEL_RST &&
        state_ff == ST_IDLE;
  endproperty
  a_reset_settings: assert property (p_reset_settings)
    else $error("Settings wrong after reset");

endmodule : tarm_arm_layer_ctrl

`default_nettype wire

/* tb/tarm_bus_partner.sv */
`default_nettype none

// Another instrument on the shared trigger bus
module tarm_bus_partner
  import tarm_pkg::*;
(
  // Clock
  input  wire logic                 ref_clk,
  // Command from the bench
  input  wire logic [BUS_LINES-1:0] wantLevel,
  input  wire logic [3:0]           lagCycles,
  // Lines driven onto the bus
  output var  logic [BUS_LINES-1:0] driveLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [BUS_LINES-1:0] levelQ  = '0;  // Level now on the lines
  logic [3:0]           waitCnt = '0;  // Cycles left before the new level

  // Single driver of the bus lines
  assign driveLevel = levelQ;

  // Slow or prompt answer; one clean edge per commanded change
  always @(posedge ref_clk) begin
    if (wantLevel == levelQ) begin
      waitCnt <= lagCycles;
    end else if (waitCnt != 4'h0) begin
      waitCnt <= waitCnt - 4'h1;
    end else begin
      levelQ <= wantLevel;
    end
  end
endmodule : tarm_bus_partner

`default_nettype wire

/* tb/tb_top.sv */
`default_nettype none

module tb_top
  import tarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus into the block
  logic                 ref_clk             = 1'b0;
  logic                 arst_n              = 1'b0;
  logic                 cfgLoad             = 1'b0;
  logic [REPEAT_W-1:0]  arm_repeat_total    = '0;
  logic [SEL_W-1:0]     arm_origin_select   = '0;
  logic [DELAY_W-1:0]   armDelayUs          = '0;
  logic [DELAY_W-1:0]   samplePeriodUs      = '0;
  logic                 pulseReq            = 1'b0;
  logic [BUS_LINES-1:0] bus_line_pulse_mask = '0;
  logic                 initiate            = 1'b0;
  logic                 patternArmEvent     = 1'b0;
  logic                 trigLayerDone       = 1'b0;
  // Partner command and bus
  logic [BUS_LINES-1:0] wantLevel           = '0;
  logic [3:0]           lagCycles           = '0;
  logic [BUS_LINES-1:0] partnerDrive;
  wire  [BUS_LINES-1:0] trigBusIn;
  // Observed outputs
  logic [BUS_LINES-1:0] trigBusOut;
  logic [BUS_LINES-1:0] trigBusOe_n;
  logic                 armLayerActive;
  logic                 armDelayActive;
  logic                 trigger_layer;
  logic                 sequenceDone;
  logic [REPEAT_W-1:0]  armsCompleted;
  // Bookkeeping
  int                   n_errors            = 0;
  int                   cmp_count           = 0;

  // Wired bus: partner lines or our own pulses
  assign trigBusIn = partnerDrive | (trigBusOut & ~trigBusOe_n);

  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;

  tarm_arm_layer_ctrl i_tarm_arm_layer_ctrl (
    .ref_clk, .arst_n, .cfgLoad, .arm_repeat_total, .arm_origin_select,
    .armDelayUs, .samplePeriodUs, .pulseReq, .bus_line_pulse_mask,
    .initiate, .patternArmEvent, .trigLayerDone, .trigBusIn, .trigBusOut,
    .trigBusOe_n, .armLayerActive, .armDelayActive, .trigger_layer,
    .sequenceDone, .armsCompleted
  );

  tarm_bus_partner i_tarm_bus_partner (
    .ref_clk    (ref_clk),
    .wantLevel  (wantLevel),
    .lagCycles  (lagCycles),
    .driveLevel (partnerDrive)
  );

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] expV);
    cmp_count++;
    if (seen !== expV) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", what, expV, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Wait for a level, bounded; leaves us just after an edge
  task automatic waitHi(input string what, ref logic s, input int lim);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check(what, 32'(s), 32'h1);
  endtask : waitHi

  // Latch settings with a one-cycle load strobe
  task automatic loadCfg(input logic [4:0] sel, input int rep, input int dly);
    @(posedge ref_clk);
    arm_origin_select <= sel;
    arm_repeat_total  <= REPEAT_W'(rep);
    armDelayUs        <= DELAY_W'(dly);
    cfgLoad           <= 1'b1;
    @(posedge ref_clk) cfgLoad <= 1'b0;
  endtask : loadCfg

  // Leave the initial layer
  task automatic start();
    @(posedge ref_clk) initiate <= 1'b1;
    @(posedge ref_clk) initiate <= 1'b0;
    #1;
  endtask : start

  // Arm event from pattern logic
  task automatic patArm();
    @(posedge ref_clk) patternArmEvent <= 1'b1;
    @(posedge ref_clk) patternArmEvent <= 1'b0;
    #1;
  endtask : patArm

  // Trigger layer finishes; check where the machine goes
  task automatic endTrig(input logic last);
    @(posedge ref_clk) trigLayerDone <= 1'b1;
    @(posedge ref_clk) trigLayerDone <= 1'b0;
    #1;
    check("sequenceDone", 32'(sequenceDone), 32'(last));
    check("back to arm", 32'(armLayerActive), 32'(!last));
  endtask : endTrig

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    int unsigned seedV;
    int ln, p, d, nn, n;
    logic [BUS_LINES-1:0] m;
    seedV = $urandom(6296);
    repeat (5) @(posedge ref_clk);
    #1 check("oe_n in reset", 32'(trigBusOe_n), 32'hFF);
    @(posedge ref_clk) arst_n <= 1'b1;

    // Defaults: immediate origin, single arm
    start();
    check("immediate trigger_layer", 32'(trigger_layer), 32'h1);
    check("arm layer skipped", 32'(armLayerActive), 32'h0);
    check("arms taken", 32'(armsCompleted), 32'h1);
    endTrig(1'b1);
    // Immediate origin, two arms: the trigger layer runs again at once
    loadCfg(SEL_IMMEDIATE, 2, 0);
    start();
    @(posedge ref_clk) trigLayerDone <= 1'b1;
    @(posedge ref_clk) trigLayerDone <= 1'b0;
    #1 check("immediate rearm", 32'(trigger_layer), 32'h1);
    check("second arm", 32'(armsCompleted), 32'h2);
    endTrig(1'b1);
    $display("test defaults done");

    // Pulses: second request on busy lines is ignored
    for (int r = 0; r < 2; r++) begin
      m = (r == 0) ? 8'h81 : 8'($urandom_range(1, 254));
      @(posedge ref_clk);
      pulseReq            <= 1'b1;
      bus_line_pulse_mask <= m;
      @(posedge ref_clk) bus_line_pulse_mask <= 8'hFF;
      @(posedge ref_clk) pulseReq <= 1'b0;
      #1 check("pulse lines", 32'(trigBusOut), 32'hFF);
      repeat (248) @(posedge ref_clk);
      #1 check("last high cycle", 32'(trigBusOut), 32'hFF);
      @(posedge ref_clk);
      #1 check("first lines end", 32'(trigBusOut), 32'(8'(~m)));
      check("oe_n follows", 32'(trigBusOe_n), 32'(m));
      @(posedge ref_clk);
      #1 check("all lines end", 32'(trigBusOut), 32'h00);
    end
    $display("test pulses done");

    // Every edge origin, wrong line first
    for (int code = 2; code <= 17; code++) begin
      ln = (code - 2) % 8;
      @(posedge ref_clk);
      lagCycles <= 4'($urandom_range(0, 9));
      wantLevel <= (code >= 10) ? 8'hFF : 8'h00;
      repeat (16) @(posedge ref_clk);
      loadCfg(5'(code), 1, 0);
      start();
      check("in arm layer", 32'(armLayerActive), 32'h1);
      @(posedge ref_clk) wantLevel <= wantLevel ^ (8'h01 << ((ln + 1) % 8));
      repeat (16) @(posedge ref_clk);
      #1 check("other line ignored", 32'(armsCompleted), 32'h0);
      @(posedge ref_clk) wantLevel <= wantLevel ^ (8'h01 << ln);
      waitHi("edge arm", armDelayActive, 20);
      check("one arm event", 32'(armsCompleted), 32'h1);
      waitHi("trigger_layer after arm", trigger_layer, 5);
      endTrig(1'b1);
    end
    $display("test edges done");

    // Arm count three, pattern origin
    loadCfg(SEL_PATTERN, 3, 0);
    start();
    for (int k = 1; k <= 3; k++) begin
      check("awaiting arm", 32'(armLayerActive), 32'h1);
      patArm();
      waitHi("pattern arm", trigger_layer, 6);
      check("arm tally", 32'(armsCompleted), 32'(k));
      endTrig(k == 3);
    end
    $display("test repeat done");

    // Unlimited arms, then reset in mid-run
    loadCfg(SEL_PATTERN, 0, 0);
    start();
    for (int k = 1; k <= 4; k++) begin
      patArm();
      waitHi("endless arm", trigger_layer, 6);
      endTrig(1'b0);
    end
    @(posedge ref_clk) arst_n <= 1'b0;
    #1 check("reset tally", 32'(armsCompleted), 32'h0);
    @(posedge ref_clk) arst_n <= 1'b1;
    start();
    check("reset origin", 32'(trigger_layer), 32'h1);
    endTrig(1'b1);
    $display("test endless done");

    // Arm delay rounded to whole sample periods
    for (int r = 0; r < 7; r++) begin
      p = (r == 0) ? 0 : (r == 1) ? 2 : $urandom_range(1, 3);
      d = (r == 1) ? 1 : (r == 2) ? 0 : $urandom_range(0, 6);
      nn = (p == 0) ? 0 : (d + p / 2) / p;
      @(posedge ref_clk) samplePeriodUs <= DELAY_W'(p);
      loadCfg(SEL_PATTERN, 1, d);
      start();
      patArm();
      waitHi("delay starts", armDelayActive, 6);
      n = 0;
      while (armDelayActive === 1'b1 && n < 5000) begin
        @(posedge ref_clk);
        #1;
        n++;
      end
      check("delay cycles", 32'(n), 32'(nn * p * US_CYCLES + 1));
      check("trigger_layer after delay", 32'(trigger_layer), 32'h1);
      endTrig(1'b1);
    end
    $display("test delays done");
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
